// [pwm_timebase_sync_lock.sv]
// switching timebase locked to the shared sync line, with apb registers
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module pwm_timebase_sync_lock (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_link_clk,
  input wire logic i_sync,
  output logic o_sync_o,
  output logic o_sync_oe,
  output logic o_alert_n,
  output logic o_ch0_pwm,
  output logic o_ch1_pwm,
  output logic o_ch0_skip,
  output logic o_ch1_skip,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  typedef struct packed {
    logic [2:0] phase_cfg;
    logic [15:0] period;
    logic [2:0] ctrl;
    logic [15:0] on_time;
    logic lock_loss;
    logic [2:0] tgl_sync;
    logic [15:0] cnt;
    logic [15:0] ref_per;
    logic [15:0] since_edge;
    logic ref_present;
    logic [2:0] err_run;
    logic locked;
    logic [15:0] drive_cnt;
    logic [15:0] on_len;
    logic skip;
    logic [31:0] rdata;
  } st_s;
  st_s st_r;
  st_s st_nxt;
  logic edge_tgl;
  logic ref_edge;
  logic apb_wr;
  logic apb_rd;
  logic addr_ok;
  logic [15:0] ph0;
  logic [15:0] ph1;
  logic [15:0] min_on;
  logic [15:0] err;
  logic [15:0] half;

  // ==========================================================
  // link side
  sync_edge_catch u_catch (
    .i_link_clk(i_link_clk),
    .i_rst_n(i_rst_n),
    .i_sync(i_sync),
    .o_edge_tgl(edge_tgl)
  );

  // ==========================================================
  // helpers
  always_comb begin
    ref_edge = st_r.tgl_sync[2] ^ st_r.tgl_sync[1];
    apb_wr = i_psel && i_penable && i_pwrite;
    apb_rd = i_psel && i_penable && !i_pwrite;
    case (i_paddr)
      timebase_pkg::ADDR_PHASE_CFG,
      timebase_pkg::ADDR_PERIOD,
      timebase_pkg::ADDR_CTRL,
      timebase_pkg::ADDR_MAKER_STATUS,
      timebase_pkg::ADDR_PIN_STATE,
      timebase_pkg::ADDR_ON_TIME: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
    half = {1'b0, st_r.period[15:1]};
    // phase eighths of a period from the config field
    ph0 = 16'((32'(st_r.period) * 32'(st_r.phase_cfg)) >> 3);
    ph1 = 16'((32'(st_r.period) * 32'(3'(st_r.phase_cfg + 3'h4))) >> 3);
    // minimum on-time grows at low peak current
    if (st_r.ctrl[timebase_pkg::CTRL_LOW_PEAK_BIT]) begin
      min_on = 16'(timebase_pkg::MIN_ON_LOW_PEAK_CYC);
    end else begin
      min_on = 16'(timebase_pkg::MIN_ON_CYC);
    end
    // phase error of internal count at reference edge, wrapped
    if (st_r.cnt > half) begin
      err = st_r.period - st_r.cnt;
    end else begin
      err = st_r.cnt;
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.tgl_sync = {st_r.tgl_sync[1:0], edge_tgl};
    // free-running timebase, wraps at the period
    if (st_r.cnt >= st_r.period - 16'h0001) begin
      st_nxt.cnt = 16'h0000;
    end else begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
    if (st_r.since_edge != 16'hFFFF) begin
      st_nxt.since_edge = st_r.since_edge + 16'h0001;
    end
    if (32'(st_r.since_edge) >=
        32'(st_r.period) * timebase_pkg::ABSENT_PERIODS) begin
      st_nxt.ref_present = 1'b0;
      st_nxt.locked = 1'b0;
      st_nxt.err_run = 3'h0;
    end
    // each falling edge restarts the measurement
    if (ref_edge) begin
      st_nxt.since_edge = 16'h0000;
      st_nxt.ref_present = 1'b1;
      st_nxt.ref_per = st_r.since_edge + 16'h0001;
      // edge-to-edge comparison: one edge per period only
      // timebase realigns to the reference edge
      // periods outside the lock range are not followed
      // a source ignores the echo of its own pulse
      if (!st_r.ctrl[timebase_pkg::CTRL_SYNC_OUT_EN_BIT] &&
          st_r.since_edge >= 16'(timebase_pkg::LOCK_MIN_PERIOD_CYC - 1) &&
          st_r.since_edge <= 16'(timebase_pkg::LOCK_MAX_PERIOD_CYC - 1)) begin
        st_nxt.cnt = 16'h0001;
      end
      if (st_r.ref_present && err > 16'(timebase_pkg::LOCK_TOL_CYC)) begin
        if (st_r.err_run == 3'(timebase_pkg::LOCK_LOSS_CYCLES - 1)) begin
          if (st_r.locked) begin
            st_nxt.lock_loss = 1'b1;
          end
          st_nxt.locked = 1'b0;
          st_nxt.err_run = 3'h0;
        end else begin
          st_nxt.err_run = st_r.err_run + 3'h1;
        end
      end else if (st_r.ref_present) begin
        st_nxt.err_run = 3'h0;
        st_nxt.locked = 1'b1;
      end
    end
    // sync output driven low 500 ns each period
    if (st_r.ctrl[timebase_pkg::CTRL_SYNC_OUT_EN_BIT] &&
        st_r.cnt == 16'h0000) begin
      st_nxt.drive_cnt = 16'(timebase_pkg::SYNC_LOW_CYC);
    end else if (st_r.drive_cnt != 16'h0000) begin
      st_nxt.drive_cnt = st_r.drive_cnt - 16'h0001;
    end
    // sample on-time each period, skip when too short
    if (st_r.cnt == 16'h0000) begin
      st_nxt.skip = st_r.on_time < min_on;
      st_nxt.on_len = st_r.on_time;
    end
    // apb writes, access phase
    if (apb_wr) begin
      case (i_paddr)
        timebase_pkg::ADDR_PHASE_CFG:
          st_nxt.phase_cfg = i_pwdata[timebase_pkg::PHASE_FIELD_W-1:0];
        timebase_pkg::ADDR_PERIOD: st_nxt.period = i_pwdata[15:0];
        timebase_pkg::ADDR_CTRL: st_nxt.ctrl = i_pwdata[2:0];
        timebase_pkg::ADDR_ON_TIME: st_nxt.on_time = i_pwdata[15:0];
        timebase_pkg::ADDR_MAKER_STATUS: begin
          // one clears, set in same cycle wins
          if (i_pwdata[timebase_pkg::LOCK_LOSS_BIT] &&
              !(st_nxt.lock_loss && !st_r.lock_loss)) begin
            st_nxt.lock_loss = 1'b0;
          end
        end
        default: ;
      endcase
    end
    st_nxt.rdata = 32'h00000000;
    if (i_psel && !i_penable && !i_pwrite) begin
      case (i_paddr)
        timebase_pkg::ADDR_PHASE_CFG: st_nxt.rdata[2:0] = st_r.phase_cfg;
        timebase_pkg::ADDR_PERIOD: st_nxt.rdata[15:0] = st_r.period;
        timebase_pkg::ADDR_CTRL: st_nxt.rdata[2:0] = st_r.ctrl;
        timebase_pkg::ADDR_ON_TIME: st_nxt.rdata[15:0] = st_r.on_time;
        timebase_pkg::ADDR_MAKER_STATUS:
          st_nxt.rdata[timebase_pkg::LOCK_LOSS_BIT] = st_r.lock_loss;
        timebase_pkg::ADDR_PIN_STATE: begin
          // bit low while sync not clocking
          st_nxt.rdata[timebase_pkg::SYNC_CLOCKING_BIT] = st_r.ref_present;
          st_nxt.rdata[0] = st_r.locked;
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
      st_r.phase_cfg <= timebase_pkg::PHASE_CFG_RST;
      st_r.period <= timebase_pkg::PERIOD_RST;
      st_r.ctrl <= timebase_pkg::CTRL_RST;
      st_r.on_time <= timebase_pkg::ON_TIME_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs
  // without edges cnt free-runs at the programmed period
  logic [15:0] rel0;
  logic [15:0] rel1;
  always_comb begin
    rel0 = (st_r.cnt >= ph0) ? st_r.cnt - ph0 : st_r.cnt + st_r.period - ph0;
    rel1 = (st_r.cnt >= ph1) ? st_r.cnt - ph1 : st_r.cnt + st_r.period - ph1;
  end

  logic ch0_r;
  logic ch1_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ch0_r <= 1'b0;
      ch1_r <= 1'b0;
    end else begin
      // pulse uses the skip decision of its own period
      ch0_r <= !st_nxt.skip && (rel0 < st_nxt.on_len);
      ch1_r <= !st_nxt.skip && (rel1 < st_nxt.on_len);
    end
  end

  assign o_ch0_pwm = ch0_r;
  assign o_ch1_pwm = ch1_r;
  assign o_ch0_skip = st_r.skip;
  assign o_ch1_skip = st_r.skip;
  // open drain: drive low only
  assign o_sync_o = 1'b0;
  assign o_sync_oe = st_r.drive_cnt != 16'h0000;
  assign o_alert_n = !(st_r.lock_loss &&
                       !st_r.ctrl[timebase_pkg::CTRL_ALERT_MASK_BIT]);
  assign o_prdata = st_r.rdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_ok;
endmodule : pwm_timebase_sync_lock

// [pwm_timebase_sync_lock_monitor.sv]
// port-level checks of the sync-locked timebase
`timescale 1ns/1ps
module timebase_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic o_sync_o,
  input wire logic o_sync_oe,
  input wire logic o_alert_n,
  input wire logic o_ch0_pwm,
  input wire logic o_ch1_pwm,
  input wire logic o_ch0_skip,
  input wire logic o_ch1_skip,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic o_pslverr
);
  // ==========================================================
  // helpers
  logic [7:0] oe_cnt_r;
  wire logic acc = i_psel && i_penable;
  wire logic mapped = (i_paddr <= 8'h14) && (i_paddr[1:0] == 2'h0);
  wire logic wr_ctrl = acc && i_pwrite && (i_paddr == 8'h08);
  wire logic wr_flag = acc && i_pwrite && (i_paddr == 8'h0C);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oe_cnt_r <= 8'h00;
    end else if (o_sync_oe) begin
      oe_cnt_r <= oe_cnt_r + 8'h01;
    end else begin
      oe_cnt_r <= 8'h00;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ready_always_a:
    assert property (o_pready) else $error("pready low");
  bad_addr_a:
    assert property (acc && !mapped |-> o_pslverr) else $error("no pslverr");
  good_addr_a:
    assert property (acc && mapped |-> !o_pslverr) else $error("bad pslverr");
  drain_only_a:
    assert property (!o_sync_o) else $error("sync driven high");
  pull_width_a:
    assert property ($fell(o_sync_oe) |-> oe_cnt_r == 8'h7D)
      else $error("sync pull width wrong");
  mask_quiet_a:
    assert property (wr_ctrl && i_pwdata[1] |-> ##[1:2] o_alert_n)
      else $error("masked alert low");
  flag_clear_a:
    assert property (wr_flag && i_pwdata[4] |-> ##[1:2] o_alert_n)
      else $error("alert kept after clear");
  skip_idle_a:
    assert property (o_ch0_skip |-> !o_ch0_pwm && !o_ch1_pwm)
      else $error("pulse in skipped period");
  skip_both_a:
    assert property (o_ch0_skip == o_ch1_skip) else $error("skip differs");
endmodule : timebase_checker
bind pwm_timebase_sync_lock timebase_checker u_timebase_checker (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .o_sync_o(o_sync_o),
  .o_sync_oe(o_sync_oe), .o_alert_n(o_alert_n), .o_ch0_pwm(o_ch0_pwm),
  .o_ch1_pwm(o_ch1_pwm), .o_ch0_skip(o_ch0_skip), .o_ch1_skip(o_ch1_skip),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr));

// [pwm_timebase_sync_lock_test.sv]
// self-checking bench for the sync-locked timebase
`timescale 1ns/1ps
module pwm_timebase_sync_lock_test;
  typedef struct packed {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
  } row_s;
  logic i_clk, i_rst_n, i_link_clk, i_psel, i_penable, i_pwrite, part_en;
  logic [7:0] i_paddr, part_per;
  logic [31:0] i_pwdata, o_prdata, rdat;
  logic o_sync_o, o_sync_oe, o_alert_n, o_ch0_pwm, o_ch1_pwm, perr, pull;
  logic o_ch0_skip, o_ch1_skip, o_pready, o_pslverr;
  wire logic i_sync = !(o_sync_oe || pull);
  int err_count, n_tests, cyc;
  row_s rows [10] = '{
    '{1'h0, 8'h00, 32'h0, 32'h7, 32'h4}, '{1'h0, 8'h04, 32'h0, 32'hFFFF, 32'h1F4},
    '{1'h0, 8'h08, 32'h0, 32'h7, 32'h0}, '{1'h0, 8'h14, 32'h0, 32'hFFFF, 32'h0},
    '{1'h0, 8'h0C, 32'h0, 32'h10, 32'h0}, '{1'h0, 8'h10, 32'h0, 32'h400, 32'h0},
    '{1'h1, 8'h00, 32'hF, 32'h7, 32'h7}, '{1'h1, 8'h00, 32'h0, 32'h7, 32'h0},
    '{1'h1, 8'h14, 32'h28, 32'hFFFF, 32'h28}, '{1'h1, 8'h40, 32'h5, 32'hF, 32'h0}};
  pwm_timebase_sync_lock u_pwm_timebase_sync_lock (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_link_clk(i_link_clk),
    .i_sync(i_sync), .o_sync_o(o_sync_o), .o_sync_oe(o_sync_oe),
    .o_alert_n(o_alert_n), .o_ch0_pwm(o_ch0_pwm), .o_ch1_pwm(o_ch1_pwm),
    .o_ch0_skip(o_ch0_skip), .o_ch1_skip(o_ch1_skip), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr));
  sync_partner u_sync_partner (.i_link_clk(i_link_clk), .i_en(part_en),
    .i_period(part_per), .o_pull(pull));
  // ==========================================================
  // clocks and tasks
  initial begin
    i_clk = 1'h0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    i_link_clk = 1'h0;
    #3;
    forever #16 i_link_clk = ~i_link_clk;
  end
  task automatic test_done();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clk);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'h1;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_pready !== 1'h1 && k < 50);
    if (o_pready !== 1'h1) begin
      err_count++;
      test_done();
    end
    rdat = o_prdata;
    perr = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask : apb
  function automatic logic pick(input int s);
    case (s)
      0: return o_ch0_pwm;
      1: return o_ch1_pwm;
      2: return o_sync_oe;
      3: return o_alert_n;
      default: return o_ch0_skip;
    endcase
  endfunction : pick
  task automatic waitfor(input int s, input logic v, input int lim);
    int k;
    k = 0;
    while (pick(s) !== v && k < lim) begin
      @(posedge i_clk);
      k++;
      cyc++;
    end
    if (k >= lim) begin
      err_count++;
      test_done();
    end
  endtask : waitfor
  task automatic rise(input int s);
    waitfor(s, 1'h0, 1400);
    waitfor(s, 1'h1, 1400);
  endtask : rise
  task automatic span(input int s, input int lo, input int hi);
    cyc = 0;
    rise(s);
    chk(cyc >= lo && cyc <= hi, 1);
  endtask : span
  // ==========================================================
  // main sequence
  initial begin
    i_rst_n = 1'h0;
    {i_psel, i_penable, i_pwrite, part_en} = 4'h0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    part_per = 8'h3C;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'h1;
    @(posedge i_clk);
    chk(o_alert_n, 1);
    chk(o_sync_oe, 0);
    foreach (rows[i]) begin
      if (rows[i].w) apb(1'h1, rows[i].a, rows[i].d);
      apb(1'h0, rows[i].a, 32'h0);
      chk(rdat & rows[i].m, rows[i].e);
      chk(perr, rows[i].a == 8'h40);
    end
    apb(1'h1, 8'h08, 32'h1);
    rise(2);
    span(2, 498, 502);
    apb(1'h0, 8'h10, 32'h0);
    chk(rdat[10], 1);
    apb(1'h1, 8'h08, 32'h0);
    repeat (2600) @(posedge i_clk);
    apb(1'h0, 8'h10, 32'h0);
    chk(rdat[10], 0);
    rise(0);
    span(0, 498, 502);
    part_en <= 1'h1;
    repeat (3000) @(posedge i_clk);
    rise(0);
    span(0, 478, 482);
    // follower keeps the shared nominal period
    apb(1'h1, 8'h04, 32'h1E0);
    rise(0);
    // channels spaced half a period apart
    span(1, 238, 242);
    apb(1'h1, 8'h14, 32'hA);
    waitfor(4, 1'h1, 1100);
    chk(o_ch0_skip, 1);
    apb(1'h1, 8'h14, 32'h1C);
    apb(1'h1, 8'h08, 32'h4);
    repeat (1000) @(posedge i_clk);
    waitfor(4, 1'h1, 600);
    chk(o_ch1_skip, 1);
    apb(1'h1, 8'h08, 32'h0);
    repeat (1000) @(posedge i_clk);
    rise(0);
    span(0, 478, 482);
    part_per <= 8'h19;
    waitfor(3, 1'h0, 9000);
    chk(o_alert_n, 0);
    apb(1'h1, 8'h08, 32'h2);
    repeat (3) @(posedge i_clk);
    chk(o_alert_n, 1);
    part_en <= 1'h0;
    repeat (40) @(posedge i_clk);
    apb(1'h0, 8'h0C, 32'h0);
    chk(rdat[4], 1);
    apb(1'h1, 8'h08, 32'h0);
    apb(1'h1, 8'h0C, 32'h0);
    apb(1'h0, 8'h0C, 32'h0);
    chk(rdat[4], 1);
    chk(o_alert_n, 0);
    apb(1'h1, 8'h0C, 32'h10);
    apb(1'h0, 8'h0C, 32'h0);
    chk(rdat[4], 0);
    chk(o_alert_n, 1);
    test_done();
  end
endmodule : pwm_timebase_sync_lock_test

// [sync_edge_catch.sv]
// link-side sampler of the sync pin with a toggle per falling edge
`timescale 1ns/1ps
module sync_edge_catch (
  input wire logic i_link_clk,
  input wire logic i_rst_n,
  input wire logic i_sync,
  output logic o_edge_tgl
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic tgl;
  } st_s;
  st_s st_r;
  st_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = i_sync;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // every falling transition counts as a reference edge
    if (st_r.s3 && !st_r.s2) begin
      st_nxt.tgl = !st_r.tgl;
    end
  end

  always_ff @(posedge i_link_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_edge_tgl = st_r.tgl;
endmodule : sync_edge_catch

// [sync_partner.sv]
// clock source sharing the sync line, stepped on the link clock
`timescale 1ns/1ps
module sync_partner (
  input wire logic i_link_clk,
  input wire logic i_en,
  input wire logic [7:0] i_period,
  output logic o_pull
);
  // ==========================================================
  // period counter, low pulse of 16 link cycles
  logic [7:0] cnt_r;
  always_ff @(posedge i_link_clk) begin
    if (!i_en || cnt_r >= i_period - 8'h01) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  assign o_pull = i_en && (cnt_r < 8'h10);
endmodule : sync_partner

// [timebase_pkg.sv]
// package of constants for the switching timebase with sync lock
package timebase_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_PHASE_CFG = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_MAKER_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_PIN_STATE = 8'h10;
  localparam logic [7:0] ADDR_ON_TIME = 8'h14;
  // ==========================================================
  // field positions
  localparam int LOCK_LOSS_BIT = 4;
  localparam int SYNC_CLOCKING_BIT = 10;
  localparam int CTRL_SYNC_OUT_EN_BIT = 0;
  localparam int CTRL_ALERT_MASK_BIT = 1;
  localparam int CTRL_LOW_PEAK_BIT = 2;
  localparam int PHASE_FIELD_W = 3;
  // ==========================================================
  // reset values
  localparam logic [2:0] PHASE_CFG_RST = 3'h4;
  localparam logic [15:0] PERIOD_RST = 16'h01F4;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [15:0] ON_TIME_RST = 16'h0000;
  // ==========================================================
  // timing, 4 ns system clock, 32 ns link clock period
  localparam int CLK_PERIOD_NS = 4;
  localparam int MIN_ON_NS = 90;
  localparam int MIN_ON_LOW_PEAK_NS = 130;
  localparam int MIN_ON_CYC = (MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_ON_LOW_PEAK_CYC =
    (MIN_ON_LOW_PEAK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_LOW_NS = 500;
  localparam int SYNC_LOW_CYC = SYNC_LOW_NS / CLK_PERIOD_NS;
  // lock range 200 kHz to 1 MHz: periods 5000 ns to 1000 ns
  localparam int LOCK_MIN_PERIOD_NS = 1000;
  localparam int LOCK_MAX_PERIOD_NS = 5000;
  localparam int LOCK_MIN_PERIOD_CYC = LOCK_MIN_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LOCK_MAX_PERIOD_CYC =
    (LOCK_MAX_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ABSENT_PERIODS = 4;
  localparam int LOCK_TOL_CYC = 8;
  localparam int LOCK_LOSS_CYCLES = 4;
endpackage : timebase_pkg
